// ---- p3m_pin_mux.v ----
/*
 Pin-function multiplexer and input pull-up control for an 8-bit port.
 Assumes control registers, serial blocks and power-mode controller sit
 outside and present their bits as synchronous ports.
*/
`timescale 1ns/10ps
`include "p3m_defs.vh"

// Operation
// R1: Select zero gives general I/O by direction
// R2: Output-b select drives pin 5 serial out
// R3: Input-b select makes pin 4 serial in
// R4: Clock-b pin 3 input if field 111
// R5: Output-a select drives pin 2 serial out
// R6: Input-a select makes pin 1 serial in
// R7: Clock-a pin 0 input when external bit
// R8: Clock-a pin 0 output when internal clock
// R9: Hi-Z in reset/standby, hold in sleeps
// R10: Standby pins with pull-up read high
// R11: Pull-up only when input and enabled; code gates on the direction bit, so alternate-output pins can get pull-up
// R12: Pull-ups off right after reset
// R13: Select bits clear to zero on reset
module p3m_pin_mux (
   input  wire       clk,
   input  wire       rst_n,
   input  wire       clk_en,
   input  wire [7:0] pin_function_select_reg,
   input  wire [7:0] direction_control_reg,
   input  wire [7:0] pullup_control_reg,
   input  wire [7:0] port_data_out,
   input  wire [2:0] clock_source_field_b,
   input  wire       external_clock_bit_a,
   input  wire [2:0] power_mode,
   input  wire       serial_out_a,
   input  wire       serial_clock_out_a,
   input  wire       serial_out_b,
   input  wire       serial_clock_out_b,
   input  wire       chip_select_alt,
   input  wire       strobe_alt,
   input  wire [7:0] pin_in,
   output reg  [7:0] pin_out,
   output reg  [7:0] pin_oe,
   output reg  [7:0] pullup_on,
   output reg  [7:0] port_read,
   output reg        serial_in_a,
   output reg        serial_clock_in_a,
   output reg        serial_in_b,
   output reg        serial_clock_in_b
);

   // ========================================
   // Select register copy
   reg  [7:0] sel_q;
   reg  [7:0] sel_d;
   reg  [7:0] oe_d;
   reg  [7:0] out_d;
   reg  [7:0] pu_d;
   reg  [7:0] rd_d;
   wire       frozen;
   wire       hiz;
   wire       clk_b_in;
   wire       clk_a_in;

   // Sleep, subsleep and watch keep every pin as it was
   assign frozen = (power_mode == `P3M_MODE_SLEEP) ||
                   (power_mode == `P3M_MODE_SUBSLP) ||
                   (power_mode == `P3M_MODE_WATCH);            // [R9]
   assign hiz    = (power_mode == `P3M_MODE_STANDBY);          // [R9]
   assign clk_b_in = (clock_source_field_b == `P3M_CKS_EXT_B); // [R4]
   assign clk_a_in = external_clock_bit_a;                     // [R7]

   // Alternate-function output value for a pin, reused per bit
   function alt_out;
      input [2:0] idx;
      begin
         case (idx)
            3'h0:    alt_out = serial_clock_out_a;
            3'h2:    alt_out = serial_out_a;
            3'h3:    alt_out = serial_clock_out_b;
            3'h5:    alt_out = serial_out_b;
            3'h6:    alt_out = strobe_alt;
            default: alt_out = 1'b0;
         endcase
      end
   endfunction

   // Pin direction and drive under each select
   always @* begin
      sel_d = pin_function_select_reg;
      out_d = port_data_out;
      oe_d  = direction_control_reg;                           // [R1]
      // Alternate outputs override the direction bit
      if (sel_q[`P3M_BIT_OUT_B]) begin
         oe_d[5]  = 1'b1;                                      // [R2]
         out_d[5] = alt_out(3'h5);
      end
      if (sel_q[`P3M_BIT_IN_B])
         oe_d[4] = 1'b0;                                       // [R3]
      if (sel_q[`P3M_BIT_CLK_B]) begin
         oe_d[3]  = ~clk_b_in;                                 // [R4]
         out_d[3] = alt_out(3'h3);
      end
      if (sel_q[`P3M_BIT_OUT_A]) begin
         oe_d[2]  = 1'b1;                                      // [R5]
         out_d[2] = alt_out(3'h2);
      end
      if (sel_q[`P3M_BIT_IN_A])
         oe_d[1] = 1'b0;                                       // [R6]
      if (sel_q[`P3M_BIT_CLK_A]) begin
         oe_d[0]  = ~clk_a_in;                                 // [R7] [R8]
         out_d[0] = alt_out(3'h0);
      end
      if (sel_q[6]) begin
         oe_d[6]  = 1'b1;
         out_d[6] = alt_out(3'h6);
      end
      if (sel_q[7])
         oe_d[7] = 1'b0;
      // Pull-up follows the raw direction bit, not the alternate drive
      pu_d = pullup_control_reg & ~direction_control_reg;      // [R11]
      // Output pins read back the latch, inputs the pin
      rd_d = (direction_control_reg & port_data_out) |
             (~direction_control_reg & pin_in);
      if (hiz) begin
         oe_d  = 8'h00;                                        // [R9]
         // Pull-up holds the floating pin high in standby
         out_d = pu_d;                                         // [R10]
      end
   end

   // ========================================
   // Registered outputs; frozen modes hold everything
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sel_q             <= `P3M_SEL_RST;                    // [R13]
         pin_oe            <= 8'h00;                           // [R9]
         pin_out           <= 8'h00;
         pullup_on         <= `P3M_PU_RST;                     // [R12]
         port_read         <= 8'h00;
         serial_in_a       <= 1'b0;
         serial_clock_in_a <= 1'b0;
         serial_in_b       <= 1'b0;
         serial_clock_in_b <= 1'b0;
      end else if (clk_en && !frozen) begin
         sel_q             <= sel_d;
         pin_oe            <= oe_d;
         pin_out           <= out_d;
         pullup_on         <= pu_d;
         port_read         <= rd_d;
         // Idle serial inputs read low when the pin is not routed
         serial_in_a       <= sel_q[`P3M_BIT_IN_A] & pin_in[1];  // [R6]
         serial_in_b       <= sel_q[`P3M_BIT_IN_B] & pin_in[4];  // [R3]
         serial_clock_in_a <= sel_q[`P3M_BIT_CLK_A] & clk_a_in &
                              pin_in[0];                       // [R7]
         serial_clock_in_b <= sel_q[`P3M_BIT_CLK_B] & clk_b_in &
                              pin_in[3];                       // [R4]
      end
   end

endmodule // p3m_pin_mux

// ---- p3m_defs.vh ----
/*
 Constants for the port pin-function multiplexer: select bit positions,
 reset values and power-mode codes. Assumes inclusion by bare name.
*/
`ifndef P3M_DEFS_VH
`define P3M_DEFS_VH
// ========================================
// Select bit positions
`define P3M_BIT_CLK_A    0
`define P3M_BIT_IN_A     1
`define P3M_BIT_OUT_A    2
`define P3M_BIT_CLK_B    3
`define P3M_BIT_IN_B     4
`define P3M_BIT_OUT_B    5
// ========================================
// Reset values and the external clock-b field code
`define P3M_SEL_RST      8'h00
`define P3M_PU_RST       8'h00
`define P3M_CKS_EXT_B    3'h7
// ========================================
// Power-mode codes
`define P3M_MODE_ACTIVE  3'h0
`define P3M_MODE_SUBACT  3'h1
`define P3M_MODE_SLEEP   3'h2
`define P3M_MODE_SUBSLP  3'h3
`define P3M_MODE_WATCH   3'h4
`define P3M_MODE_STANDBY 3'h5
`endif

// ---- p3m_pins.sv ----
/* Outside circuit on the eight port pins.
   Assumes the bench supplies what it drives onto released pins. */
`timescale 1ns/10ps
module p3m_pins (
   input  wire logic [7:0] pin_out, pin_oe, ext_drv,
   output wire logic [7:0] pin_level
);
   // ======
   // Outside drive holds every released pin, so no input ever floats
   assign pin_level = pin_oe & pin_out | ~pin_oe & ext_drv;
endmodule // p3m_pins

// ---- p3m_chk.sv ----
/* Port mux checker.
   Assumes it is bound to the mux and sees only its ports. */
`timescale 1ns/10ps
module p3m_chk (
   input wire logic       clk, rst_n, clk_en, external_clock_bit_a,
   input wire logic [7:0] pin_function_select_reg, direction_control_reg,
   input wire logic [7:0] pullup_control_reg, pin_oe, pin_out, pullup_on,
   input wire logic [2:0] clock_source_field_b, power_mode
);
   // ======
   // Routing is judged in run modes only; standby releases every pin
   wire       en = clk_en && power_mode < 3'h2;
   wire [7:0] s  = pin_function_select_reg;
   wire [7:0] d  = direction_control_reg;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_pullup_gate: assert property (
      en |=> pullup_on == ($past(pullup_control_reg) & ~$past(d)))
      else $error("pull-up");
   a_standby_off: assert property (
      clk_en && power_mode == 3'h5 |=> !pin_oe && pin_out == pullup_on)
      else $error("standby");
   a_sleep_hold: assert property (
      power_mode inside {[3'h2:3'h4]} |=> $stable({pin_oe, pin_out}))
      else $error("hold");
   a_gpio_dir: assert property (en && !s[5] ##1 en |=>
      pin_oe[5] == $past(d[5])) else $error("gpio");
   a_out_b: assert property (en && s[5] ##1 en |=> pin_oe[5])
      else $error("out b");
   a_in_b: assert property (en && s[4] ##1 en |=> !pin_oe[4])
      else $error("in b");
   a_clk_b_dir: assert property (en && s[3] ##1 en |=>
      pin_oe[3] == ($past(clock_source_field_b) != 3'h7))
      else $error("clk b");
   a_clk_a_dir: assert property (en && s[0] ##1 en |=>
      pin_oe[0] == !$past(external_clock_bit_a)) else $error("clk a");
endmodule // p3m_chk

bind p3m_pin_mux p3m_chk u_chk (.*);

// ---- tb_top.sv ----
/* Port mux bench: random routing, power modes, mid-run reset.
   Assumes the mux, pin model and checker are compiled first. */
`timescale 1ns/10ps
module tb_top;
   logic        clk = 0, rst_n = 0, ce = 1;
   logic [2:0]  md = 0;
   logic [63:0] v = 0;
   logic [7:0]  lvl, po, oe, pu, pr;
   logic [3:0]  si;
   logic [35:0] q[$], last;
   int          error_cnt = 0, tests_run = 0, cyc = 0;
   event        go;
   p3m_pin_mux u_dut (.clk, .rst_n, .clk_en(ce),
      .pin_function_select_reg(v[7:0]), .direction_control_reg(v[15:8]),
      .pullup_control_reg(v[23:16]), .port_data_out(v[31:24]),
      .clock_source_field_b(v[34:32]), .external_clock_bit_a(v[35]),
      .power_mode(md), .serial_out_a(v[36]), .serial_clock_out_a(v[37]),
      .serial_out_b(v[38]), .serial_clock_out_b(v[39]),
      .chip_select_alt(v[40]), .strobe_alt(v[41]), .pin_in(lvl),
      .pin_out(po), .pin_oe(oe), .pullup_on(pu), .port_read(pr),
      .serial_in_a(si[0]), .serial_clock_in_a(si[1]),
      .serial_in_b(si[2]), .serial_clock_in_b(si[3]));
   p3m_pins u_pins (.pin_out(po), .pin_oe(oe), .ext_drv(v[49:42]),
      .pin_level(lvl));
   // ======
   // Clock, and a guard that cuts a hang short
   initial forever #5 clk = ~clk;
   always @(posedge clk) if (++cyc == 900) begin
      error_cnt++;
      final_report;
   end
   // Expected {serial ins, read-back, enables, driven values on enabled pins, pull-ups}
   function automatic logic [35:0] xp();
      logic [7:0] s, e, dv, l;
      s = v[7:0];
      e = v[15:8] & ~s | s & {4'h6, v[34:32] != 3'h7, 2'h2, !v[35]};
      dv = e & (v[31:24] & ~s | s & {1'b0, v[41], v[38], 1'b0,
         v[39], v[36], 1'b0, v[37]});
      // Released pins show the outside drive
      l = dv | ~e & v[49:42];
      return {s[3] & (v[34:32] == 3'h7) & l[3], s[4] & l[4],
         s[0] & v[35] & l[0], s[1] & l[1],
         v[15:8] & v[31:24] | ~v[15:8] & l, e, dv, v[23:16] & ~v[15:8]};
   endfunction
   // New random inputs, then room for the select copy to settle
   task automatic drive(input logic [2:0] m);
      @(posedge clk);
      v <= {$urandom, $urandom};
      md <= m;
      repeat (3) @(posedge clk);
   endtask
   task automatic put(input logic [35:0] e);
      q.push_back(e);
      -> go;
   endtask
   task automatic cmp(input logic [35:0] e, g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic final_report;
      $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // Watcher: oldest note against outputs once they settle
   always @(go) begin
      #1 cmp(q.pop_front(), {si, pr, oe, oe & po, pu});
      $display("test %0d done", tests_run);
   end
   // Main sequence
   initial begin
      void'($urandom(1));
      repeat (3) @(posedge clk);
      rst_n <= 1;
      for (int i = 0; i < 60; i++) begin
         drive(3'(i % 2));
         put(xp());
      end
      // Clock enable low must freeze every output
      drive(3'h0);
      last = xp();
      ce <= 1'b0;
      drive(3'h0);
      put(last);
      ce <= 1'b1;
      for (int i = 2; i < 6; i++) begin
         drive(3'h0);
         last = xp();
         drive(3'(i)); // Standby last, judged by the checker
         if (i < 5) put(last);
      end
      rst_n <= 0;
      #1 put(36'h0);
      @(posedge clk) rst_n <= 1;
      repeat (2) @(posedge clk);
      final_report;
   end
endmodule // tb_top
